// file: pkg/msbc_pkg.sv
/*
 Package for the module sideband control block: timing counts, state
 encodings and the carrier struct for the pin levels used by the core.
 Assumes a 10 MHz core clock.
*/
package msbc_pkg;
   // Core clock
   localparam int CLK_HZ = 10000000;
   // Least low time on the reset pin that counts as a reset, in us
   localparam int RESET_MIN_US = 10;
   localparam int RESET_MIN_CYC = (RESET_MIN_US * (CLK_HZ / 1000000) < 1) ? 1 :
      RESET_MIN_US * (CLK_HZ / 1000000);
   // Initialization interval after reset release, in us
   localparam int INIT_US = 400;
   localparam int INIT_CYC = (INIT_US * (CLK_HZ / 1000000) < 1) ? 1 :
      INIT_US * (CLK_HZ / 1000000);
   // Glitch filter length on select, reset and low-power inputs
   localparam int FILT_CYC = 4;
   // Counter width
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] RESET_MIN_CNT = CNT_W'(RESET_MIN_CYC);
   localparam logic [CNT_W-1:0] INIT_CNT = CNT_W'(INIT_CYC);
   localparam logic [CNT_W-1:0] FILT_CNT = CNT_W'(FILT_CYC);

   // Reset and initialization sequencer states
   typedef enum logic [1:0] {
      MSBC_ST_RUN = 2'b00,
      MSBC_ST_HELD = 2'b01,
      MSBC_ST_INIT = 2'b10
   } msbc_state_type;

   // Sideband input levels after glitch filtering
   typedef struct packed {
      logic module_select_n;
      logic module_reset_n;
      logic low_power_request;
   } msbc_pins_type;
endpackage

// file: core/msbc_filter.sv
/*
 Synchroniser and glitch filter for one sideband input.
 Assumes the input may be asynchronous to clk_i; output changes only after
 the synchronised level has been stable for the given number of cycles.
*/
`timescale 1ns/1ps
module msbc_filter
   import msbc_pkg::*;
#(
   parameter logic [CNT_W-1:0] STABLE = FILT_CNT,
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Raw level in, filtered level out
   input wire logic raw_i,
   output logic level_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic out;
      logic [CNT_W-1:0] cnt;
   } msbc_filt_type;

   msbc_filt_type st_reg;
   msbc_filt_type st_next;

   ////////////////////////////////////////////////////////////////////////
   // Next state: s1 feeds only s2; s2 is filtered
   always_comb begin
      st_next = st_reg;
      st_next.s1 = raw_i;
      st_next.s2 = st_reg.s1;
      if (st_reg.s2 == st_reg.out) begin
         st_next.cnt = '0;
      end else if (st_reg.cnt >= STABLE - 1'b1) begin
         st_next.out = st_reg.s2; // [RULE_16]
         st_next.cnt = '0;
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg <= '{s1: RST_VAL, s2: RST_VAL, out: RST_VAL, cnt: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_o = st_reg.out;
endmodule

// file: core/msbc_open_drain.sv
/*
 Open-drain output stage: pulls low or releases, never drives high.
 Assumes a pull-up on the host board sets the released level.
*/
`timescale 1ns/1ps
module msbc_open_drain (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Request to pull the line low
   input wire logic pull_low_i,
   // Pin signals
   output logic pin_o,
   output logic pin_oe_o
);
   typedef struct packed {
      logic oe;
   } msbc_od_type;

   msbc_od_type st_reg;
   msbc_od_type st_next;

   ////////////////////////////////////////////////////////////////////////
   // Enable follows the request; data is always low
   always_comb begin
      st_next.oe = pull_low_i;
   end

   // Enable register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_o = 1'b0; // [RULE_14]
   assign pin_oe_o = st_reg.oe;

   // Data never driven high while enabled
   a_od_never_high: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_14]
      pin_oe_o |-> !pin_o) else $error("open drain drove high");
endmodule

// file: core/msbc_core.sv
/*
 Sideband control core of a pluggable four-lane optical module.
 Assumes a single 10 MHz clock, power-up reset on sys_rst_i, and a host
 that pulls up the attention and present lines on its board.
*/
// Overview of operation
// (RULE_01) Select low lets the module answer two-wire management commands.
// (RULE_02) Select high: ignore all management traffic, never drive data line.
// (RULE_03) Select input has internal pull-up; floating means deselected. No pull-up here; the select filter just resets high.
// (RULE_04) Host uses each module's select line to address one module.
// (RULE_05) Reset low beyond minimum time fully resets and restores defaults.
// (RULE_06) Initialization interval starts at rising edge of reset input.
// (RULE_07) Host ignores status bits until reset completion is signalled.
// (RULE_08) Completion shown by attention asserted with data-not-ready cleared.
// (RULE_09) Power-up raises completion attention without a reset pulse.
// (RULE_10) Low-power request high selects reduced power; low runs normal.
// (RULE_11) Present output reads low when seated, high via host pull-up.
// (RULE_12) Attention pulled low for faults or critical status.
// (RULE_13) Host reads module over management bus to find the cause.
// (RULE_14) Attention only pulled low or released, never driven high.
// (RULE_15) Host reads lower page flag field to learn channel and flag.
// (RULE_16) Select, reset, low-power inputs synchronised and glitch filtered.
`timescale 1ns/1ps
module msbc_core
   import msbc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Host sideband pins
   input wire logic module_select_n_i,
   input wire logic module_reset_n_i,
   input wire logic low_power_request_i,
   // Management bus data line, open drain
   input wire logic mgmt_sda_i,
   input wire logic mgmt_sda_drive_low_i,
   output logic mgmt_sda_o,
   output logic mgmt_sda_oe_o,
   output logic mgmt_enable_o,
   // Status from module internals
   input wire logic fault_event_i,
   input wire logic flags_read_i,
   // Module state outputs
   output logic data_not_ready_o,
   output logic low_power_o,
   output logic user_defaults_o,
   output logic present_n_o,
   output logic present_n_oe_o,
   // Attention pin, open drain
   output logic attention_n_o,
   output logic attention_n_oe_o
);
   // All core state
   typedef struct packed {
      msbc_state_type state;
      logic [CNT_W-1:0] cnt;
      logic not_ready;
      logic completion;
      logic fault;
      logic low_power;
      logic defaults;
      logic mgmt_en;
      logic sda_oe;
   } msbc_core_type;

   msbc_core_type st_reg;
   msbc_core_type st_next;
   msbc_pins_type pins_filt;
   logic attn_pull;
   logic sda_unused;

   ////////////////////////////////////////////////////////////////////////
   // Input conditioning; select resets high as an undriven pin would
   msbc_filter #(.STABLE(FILT_CNT), .RST_VAL(1'b1)) u_sel (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .raw_i(module_select_n_i), // [RULE_03]
      .level_o(pins_filt.module_select_n)
   );

   // Reset pin uses a short filter; min-time check is in the sequencer
   msbc_filter #(.STABLE(FILT_CNT), .RST_VAL(1'b1)) u_rst (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .raw_i(module_reset_n_i),
      .level_o(pins_filt.module_reset_n)
   );

   msbc_filter #(.STABLE(FILT_CNT), .RST_VAL(1'b0)) u_lpm (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .raw_i(low_power_request_i),
      .level_o(pins_filt.low_power_request)
   );

   assign sda_unused = mgmt_sda_i;

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencer, attention flags and select gating
   always_comb begin
      st_next = st_reg;
      case (st_reg.state)
         MSBC_ST_RUN: begin
            if (!pins_filt.module_reset_n) begin
               st_next.state = MSBC_ST_HELD;
               st_next.cnt = '0;
            end
         end
         MSBC_ST_HELD: begin
            if (pins_filt.module_reset_n) begin
               // Short pulse: no reset; an interrupted init starts over
               if (st_reg.cnt >= RESET_MIN_CNT) begin
                  st_next.state = MSBC_ST_INIT; // [RULE_06]
                  st_next.cnt = '0;
               end else if (st_reg.not_ready) begin
                  st_next.state = MSBC_ST_INIT; // [RULE_16]
                  st_next.cnt = '0;
               end else begin
                  st_next.state = MSBC_ST_RUN; // [RULE_16]
               end
            end else if (st_reg.cnt < RESET_MIN_CNT - 1'b1) begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end else begin
               // Held long enough: defaults go back before any release
               st_next.cnt = RESET_MIN_CNT;
               st_next.defaults = 1'b1; // [RULE_05]
               st_next.not_ready = 1'b1;
               st_next.completion = 1'b0;
               st_next.fault = 1'b0;
            end
         end
         MSBC_ST_INIT: begin
            st_next.defaults = 1'b0;
            if (!pins_filt.module_reset_n) begin
               st_next.state = MSBC_ST_HELD;
               st_next.cnt = '0;
            end else if (st_reg.cnt >= INIT_CNT - 1'b1) begin
               st_next.state = MSBC_ST_RUN;
               st_next.not_ready = 1'b0; // [RULE_08]
               st_next.completion = 1'b1;
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
         default: begin
            st_next.state = MSBC_ST_RUN;
         end
      endcase
      // Host read clears attention causes; a new fault wins over the clear
      if (flags_read_i && st_reg.state == MSBC_ST_RUN) begin
         st_next.completion = 1'b0;
         st_next.fault = 1'b0;
      end
      if (fault_event_i && st_reg.state == MSBC_ST_RUN) begin
         st_next.fault = 1'b1; // [RULE_12]
      end
      st_next.low_power = pins_filt.low_power_request; // [RULE_10]
      st_next.mgmt_en = !pins_filt.module_select_n; // [RULE_01]
      st_next.sda_oe = !pins_filt.module_select_n && mgmt_sda_drive_low_i; // [RULE_02]
   end

   // State register; power-up starts in the init interval
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg <= '{state: MSBC_ST_INIT, cnt: '0, not_ready: 1'b1,
            completion: 1'b0, fault: 1'b0, low_power: 1'b0, defaults: 1'b1,
            mgmt_en: 1'b0, sda_oe: 1'b0}; // [RULE_09]
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Attention pin stage
   assign attn_pull = st_next.completion || st_next.fault;

   msbc_open_drain u_attn (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pull_low_i(attn_pull), // [RULE_12]
      .pin_o(attention_n_o),
      .pin_oe_o(attention_n_oe_o)
   );

   // Plain outputs
   assign mgmt_sda_o = 1'b0;
   assign mgmt_sda_oe_o = st_reg.sda_oe;
   assign mgmt_enable_o = st_reg.mgmt_en;
   assign data_not_ready_o = st_reg.not_ready;
   assign low_power_o = st_reg.low_power;
   assign user_defaults_o = st_reg.defaults;
   // Present pin grounded inside the module whenever seated
   assign present_n_o = 1'b0; // [RULE_11]
   assign present_n_oe_o = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Data line stays released while deselected
   a_sda_desel_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
      $past(pins_filt.module_select_n) |-> !mgmt_sda_oe_o)
      else $error("data line driven while deselected");

   // Deselect turns the management engine off
   a_desel_no_mgmt: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
      pins_filt.module_select_n |=> !mgmt_enable_o)
      else $error("deselected but management enabled");

   // Select turns the management engine on
   a_sel_enables_mgmt: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
      !pins_filt.module_select_n |=> mgmt_enable_o)
      else $error("selected but management disabled");

   // Data line is only pulled by an enabled engine
   a_sda_needs_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
      mgmt_sda_oe_o |-> mgmt_enable_o)
      else $error("data line pulled while not enabled");

   // Completion attention follows the fall of not-ready
   a_completion_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_08]
      $fell(data_not_ready_o) |-> ##1 !attention_n_o && attention_n_oe_o)
      else $error("completion attention missing");

   // Completion is only posted with status valid
   a_completion_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_08]
      st_reg.completion |-> !data_not_ready_o)
      else $error("completion posted while not ready");

   // No attention during the init interval
   a_init_no_attn: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_08]
      st_reg.state == MSBC_ST_INIT |-> !attention_n_oe_o)
      else $error("attention during init");

   // Init starts at the release of a long reset
   a_init_on_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_06]
      (st_reg.state == MSBC_ST_HELD && st_reg.cnt >= RESET_MIN_CNT
       && pins_filt.module_reset_n) |=> st_reg.state == MSBC_ST_INIT)
      else $error("init not started at release");

   // Init runs its full length while the pin stays high
   a_init_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_06]
      (st_reg.state == MSBC_ST_INIT && st_reg.cnt < INIT_CNT - 1'b1
       && pins_filt.module_reset_n) |=> st_reg.state == MSBC_ST_INIT)
      else $error("init cut short");

   // Status reads not ready for the whole init
   a_init_not_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_06]
      st_reg.state == MSBC_ST_INIT |-> data_not_ready_o)
      else $error("ready during init");

   // Not ready only falls at the end of init
   a_ready_at_end: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_06]
      $fell(data_not_ready_o) |-> $past(st_reg.state) == MSBC_ST_INIT)
      else $error("ready outside the end of init");

   // A low reset pin leaves run at once
   a_held_entry: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_05]
      (st_reg.state == MSBC_ST_RUN && !pins_filt.module_reset_n)
      |=> st_reg.state == MSBC_ST_HELD)
      else $error("reset pin not seen");

   // Long reset restores defaults
   a_long_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_05]
      (st_reg.state == MSBC_ST_HELD && st_reg.cnt >= RESET_MIN_CNT
       && !pins_filt.module_reset_n) |=> user_defaults_o && data_not_ready_o)
      else $error("long reset did not restore defaults");

   // Defaults are never applied in run
   a_defaults_not_run: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_05]
      user_defaults_o |-> st_reg.state != MSBC_ST_RUN)
      else $error("defaults applied in run");

   // Short pulse keeps settings; an interrupted init starts over
   a_short_glitch: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_16]
      (st_reg.state == MSBC_ST_HELD && st_reg.cnt < RESET_MIN_CNT
       && pins_filt.module_reset_n) |=> !user_defaults_o
       && st_reg.state == ($past(st_reg.not_ready) ? MSBC_ST_INIT : MSBC_ST_RUN))
      else $error("short pulse reset module");

   // Low-power request high gives reduced power
   a_lowpower_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_10]
      pins_filt.low_power_request |=> low_power_o)
      else $error("low power not entered");

   // Low-power request low gives normal power
   a_lowpower_normal: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_10]
      !pins_filt.low_power_request |=> !low_power_o)
      else $error("low power not left");

   // Fault in run pulls attention
   a_fault_attn: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_12]
      (fault_event_i && st_reg.state == MSBC_ST_RUN) |-> ##1 attention_n_oe_o)
      else $error("fault did not pull attention");

   // Attention pin tracks its pending causes
   a_attn_tracks: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_12]
      attention_n_oe_o == (st_reg.completion || st_reg.fault))
      else $error("attention out of step with causes");

   // A read with no new fault releases attention
   a_read_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_12]
      (flags_read_i && !fault_event_i && st_reg.state == MSBC_ST_RUN) |=> !attention_n_oe_o)
      else $error("attention not released by read");

   // Attention only ever pulls low
   a_attn_pulls_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_14]
      attention_n_oe_o |-> !attention_n_o)
      else $error("attention driven high");

   // Present is grounded inside the module
   a_present_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_11]
      present_n_oe_o && !present_n_o)
      else $error("present not low");

   // Power-up: defaults drop while still not ready
   a_powerup_done: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_09]
      $fell(st_reg.defaults) && $past(st_reg.state) == MSBC_ST_INIT
      |-> data_not_ready_o)
      else $error("not ready lost early");
endmodule

// file: sim/msbc_host_model.sv
/*
 Host board model for the sideband core: pull-ups on the open-drain lines,
 the select line, and the flag read that answers an attention request.
 Assumes one module per select line and the core clock shared with the board.
*/
`timescale 1ns/1ps
module msbc_host_model (
   // Clock
   input wire logic clk_i,
   // Host select control and core pin drives
   input wire logic sel_drive_low_i,
   input wire logic sda_oe_i,
   input wire logic att_oe_i,
   input wire logic prs_o_i,
   input wire logic prs_oe_i,
   input wire logic data_not_ready_i,
   // Wire levels and host read strobe
   output logic select_n_o,
   output logic sda_o,
   output logic attention_n_o,
   output logic present_n_o,
   output logic flags_read_o
);
   logic [2:0] wait_reg;
   // One select line per module; a released line floats high
   assign select_n_o = sel_drive_low_i ? 1'b0 : 1'b1;
   // Board pull-ups set the released level of open-drain lines
   assign sda_o = sda_oe_i ? 1'b0 : 1'b1;
   assign attention_n_o = att_oe_i ? 1'b0 : 1'b1;
   assign present_n_o = prs_oe_i ? prs_o_i : 1'b1;
   // Reads the flag field a few cycles after attention, once status is valid
   always @(posedge clk_i) begin
      flags_read_o <= 1'b0;
      if (attention_n_o || data_not_ready_i) begin
         wait_reg <= 3'h0;
      end else if (wait_reg == 3'h5) begin
         flags_read_o <= 1'b1;
         wait_reg <= 3'h0;
      end else begin
         wait_reg <= wait_reg + 3'h1;
      end
   end
endmodule

// file: sim/tb.sv
/*
 Self-checking bench for the sideband core: power-up completion, select and
 low-power table, glitch refusal, pin reset, fault attention, mid-run reset.
 Assumes the host board model in its own file and a 10 MHz clock.
*/
`timescale 1ns/1ps
module tb;
   import msbc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sel_drv = 1'b0;
   logic rst_pin = 1'b1;
   logic lp_req = 1'b0;
   logic drive_low = 1'b0;
   logic fault = 1'b0;
   logic sel_n, sda, flags_rd, sda_o, sda_oe, en, nrdy, lp, dflt;
   logic prs_o, prs_oe, att_o, att_oe, att_line, prs_line;
   int fail_count = 0;
   int checks = 0;
   int n;
   // Rows: select drive, low power, drive low, then enable, data oe, low power
   logic [5:0] rows [4] = '{6'h24, 6'h3f, 6'h08, 6'h11};
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   msbc_core i_dut (.clk_i(clk), .sys_rst_i(rst), .module_select_n_i(sel_n),
      .module_reset_n_i(rst_pin), .low_power_request_i(lp_req), .mgmt_sda_i(sda),
      .mgmt_sda_drive_low_i(drive_low), .mgmt_sda_o(sda_o), .mgmt_sda_oe_o(sda_oe),
      .mgmt_enable_o(en), .fault_event_i(fault), .flags_read_i(flags_rd),
      .data_not_ready_o(nrdy), .low_power_o(lp), .user_defaults_o(dflt),
      .present_n_o(prs_o), .present_n_oe_o(prs_oe), .attention_n_o(att_o),
      .attention_n_oe_o(att_oe));
   msbc_host_model i_host (.clk_i(clk), .sel_drive_low_i(sel_drv), .sda_oe_i(sda_oe),
      .att_oe_i(att_oe), .prs_o_i(prs_o), .prs_oe_i(prs_oe), .data_not_ready_i(nrdy),
      .select_n_o(sel_n), .sda_o(sda), .attention_n_o(att_line),
      .present_n_o(prs_line), .flags_read_o(flags_rd));
   ////////////////////////////////////////////////////////////////////////////
   // Steps n clocks, landing just after the edge
   task tick(input int cyc);
      repeat (cyc) @(posedge clk);
      #10;
   endtask
   // Counts one comparison and reports a miss
   task chk(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   // Prints counts and verdict, then ends the run
   task give_verdict;
      $display("mismatches %0d comparisons %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Bounded wait for the not-ready flag to fall
   task wait_ready(output int cnt);
      cnt = 0;
      while (nrdy !== 1'b0 && cnt < 5000) begin
         tick(1);
         cnt++;
      end
      if (cnt >= 5000) begin
         chk(1'b0, "not ready never fell");
         give_verdict;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      tick(20);
      rst = 1'b0;
      chk(nrdy === 1'b1 && att_oe === 1'b0, "outputs at release");
      wait_ready(n);
      chk(n >= INIT_CYC - 3 && n <= INIT_CYC + 3, "power-up init length");
      tick(1);
      chk(att_line === 1'b0 && nrdy === 1'b0, "completion attention");
      chk(att_o === 1'b0 && prs_line === 1'b0, "open drain and present");
      tick(10);
      chk(att_line === 1'b1, "attention cleared by read");
      for (int i = 0; i < 4; i++) begin
         {sel_drv, lp_req, drive_low} = rows[i][5:3];
         tick(12);
         chk({en, sda_oe, lp} === rows[i][2:0], "select table");
      end
      // Short pulses on reset and select are refused
      rst_pin = 1'b0;
      tick(50);
      rst_pin = 1'b1;
      sel_drv = 1'b1;
      tick(2);
      sel_drv = 1'b0;
      tick(20);
      chk(nrdy === 1'b0 && en === 1'b0, "glitches refused");
      // Full pin reset, then initialization from the rising edge
      rst_pin = 1'b0;
      tick(150);
      chk(nrdy === 1'b1 && dflt === 1'b1, "defaults during reset");
      rst_pin = 1'b1;
      tick(3000);
      chk(nrdy === 1'b1, "still initializing");
      wait_ready(n);
      chk(n + 3000 >= INIT_CYC && n + 3000 <= INIT_CYC + 12, "init from release");
      tick(1);
      chk(att_line === 1'b0, "reset completion attention");
      tick(10);
      // Fault raises attention, host read clears it
      fault = 1'b1;
      tick(1);
      fault = 1'b0;
      tick(1);
      chk(att_line === 1'b0, "fault attention");
      tick(10);
      chk(att_line === 1'b1, "fault cleared");
      // Power-up reset in mid-run while pulling the data line
      sel_drv = 1'b1;
      drive_low = 1'b1;
      tick(12);
      chk(sda_oe === 1'b1 && sda === 1'b0 && sda_o === 1'b0, "data line pulled");
      rst = 1'b1;
      tick(1);
      chk(sda_oe === 1'b0 && nrdy === 1'b1 && dflt === 1'b1, "mid-run reset");
      rst = 1'b0;
      tick(2);
      chk(nrdy === 1'b1 && att_oe === 1'b0 && dflt === 1'b0, "after release");
      tick(98);
      // Short reset glitch during init restarts the interval
      rst_pin = 1'b0;
      tick(50);
      rst_pin = 1'b1;
      wait_ready(n);
      chk(n >= INIT_CYC && n <= INIT_CYC + 12, "init restarted");
      tick(1);
      chk(att_line === 1'b0 && dflt === 1'b0, "completion after glitch");
      give_verdict;
   end
endmodule
